// >>> logic/card_host_pkg.sv
// shared constants and carrier types for the flash card host controller
package card_host_pkg;
	localparam int addr_w = 22;
	localparam int data_w = 16;
	localparam int byte_w = 8;
	localparam int zone_addr_w = 18;
	localparam logic [7:0] read_cmd = 8'h00;
	localparam int clk_period_ns = 4;
	localparam int setup_ns = 20;
	localparam int strobe_ns = 100;
	localparam int recover_ns = 20;
	localparam int access_ns = 250;
	localparam int vpp_setup_ns = 100;
	localparam int setup_cyc = (setup_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int strobe_cyc = (strobe_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int recover_cyc = (recover_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int access_cyc = (access_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int vpp_cyc = (vpp_setup_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int cnt_w = 8;

	typedef enum logic [1:0] {
		width_byte_even,
		width_byte_odd,
		width_word
	} width_mode_t;

	typedef struct packed {
		logic write;
		width_mode_t width;
		logic [addr_w-1:0] addr;
		logic [data_w-1:0] wdata;
		logic program_enable;
	} host_req_t;

	typedef struct packed {
		logic sel_low_n;
		logic sel_high_n;
		logic oe_n;
		logic we_n;
		logic program_low;
		logic program_high;
	} card_ctl_t;

	typedef enum logic [2:0] {
		st_idle,
		st_vpp,
		st_setup,
		st_strobe,
		st_recover
	} cyc_state_t;
endpackage : card_host_pkg

// >>> logic/sense_sync.sv
// two-flop synchroniser bank for card-side status pins
module sense_sync #(
	parameter int width = 1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] meta_ff;
	logic [width-1:0] sync_ff;

	// first stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < width; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					meta_ff[i] <= 1'b1;
					sync_ff[i] <= 1'b1;
				end else begin
					meta_ff[i] <= async_in[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_ff;
endmodule : sense_sync

// >>> logic/flash_card_host.sv
// host-side access controller driving a zoned flash card over its socket pins
// Function
// [R1] card is read-only unless program supply is raised; host raises it only for writes
// [R2] erase and rewrite only through command register writes with high program supply
// [R3] each zone has its own command register driving its state machine
// [R4] card latches address and data on each write cycle
// [R5] after a command, an ordinary read returns data or verify data
// [R6] erase acts on a whole 256 K-byte zone; several may run together
// [R7] erased zone takes bit or byte writes and random reads
// [R8] word mode: low select and supply own low byte, high ones own high byte
// [R9] read, write and verify are per byte or word, zone independent
// [R10] erase commands anywhere in a zone erase that zone or the pair
// [R11] byte mode: host drives only low select, data on low eight lines
// [R12] byte mode: lane bit low gives even byte, high gives odd byte
// [R13] byte-mode erase: even bytes for one zone, odd bytes for the other
// [R14] card gives two active-low grounded insertion-sense outputs
// [R15] host samples each sense bit and flags a half-seated card
// [R16] write-protect switch forces card write strobe inactive
// [R17] zone command register works only with program supply high
// [R18] command functions blocked while main supply under lockout level
// [R19] host loads commands with ordinary processor write cycles
// [R20] low program supply holds command registers at 00h
// [R21] card takes address on strobe fall, data on strobe rise
// [R22] card data lines float when deselected or output gate off
module flash_card_host
	import card_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire card_host_pkg::host_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [card_host_pkg::data_w-1:0] rsp_data,
	output logic rsp_valid,
	output logic rsp_refused,
	output logic card_present,
	output logic card_misseated,
	output logic write_protected,
	output card_host_pkg::card_ctl_t card_ctl,
	output logic [card_host_pkg::addr_w-1:0] card_addr,
	output logic [card_host_pkg::byte_w-1:0] data_low_lane_out,
	output logic [card_host_pkg::byte_w-1:0] data_high_lane_out,
	output logic data_low_lane_oe,
	output logic data_high_lane_oe,
	input wire logic [card_host_pkg::byte_w-1:0] data_low_lane_in,
	input wire logic [card_host_pkg::byte_w-1:0] data_high_lane_in,
	input wire logic insert_sense_first_n,
	input wire logic insert_sense_second_n,
	input wire logic write_protect_pin
);
	import card_host_pkg::*;

	logic [2:0] sense_sync_out;
	cyc_state_t state_ff;
	logic [cnt_w-1:0] cnt_ff;
	host_req_t cur_ff;
	card_ctl_t ctl_ff;
	logic [addr_w-1:0] addr_ff;
	logic [byte_w-1:0] lo_out_ff;
	logic [byte_w-1:0] hi_out_ff;
	logic lo_oe_ff;
	logic hi_oe_ff;
	logic ready_ff;
	logic [data_w-1:0] rsp_data_ff;
	logic rsp_valid_ff;
	logic refused_ff;
	logic present_ff;
	logic misseat_ff;
	logic wp_ff;
	logic sense_a;
	logic sense_b;
	logic wp_s;
	logic [cnt_w-1:0] vpp_len;
	logic [cnt_w-1:0] setup_len;
	logic [cnt_w-1:0] strobe_len;
	logic [cnt_w-1:0] recover_len;
	logic [cnt_w-1:0] access_len;
	logic [data_w-1:0] rd_word;
	logic [data_w-1:0] data_sync;

	assign vpp_len = cnt_w'(vpp_cyc);
	assign setup_len = cnt_w'(setup_cyc);
	assign strobe_len = cnt_w'(strobe_cyc);
	assign recover_len = cnt_w'(recover_cyc);
	assign access_len = cnt_w'(access_cyc);

	// card pins are asynchronous to ref_clk
	sense_sync #(
		.width(3)
	) u_sense_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.async_in({write_protect_pin, insert_sense_second_n, insert_sense_first_n}),
		.sync_out(sense_sync_out)
	);
	assign sense_a = sense_sync_out[0];
	assign sense_b = sense_sync_out[1];
	assign wp_s = sense_sync_out[2];

	// data lanes are card pins too; the long access window absorbs the two-cycle lag
	sense_sync #(
		.width(data_w)
	) u_data_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.async_in({data_high_lane_in, data_low_lane_in}),
		.sync_out(data_sync)
	);

	// both sense bits low means seated; one alone means crooked insertion
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			present_ff <= 1'b0;
			misseat_ff <= 1'b0;
			wp_ff <= 1'b0;
		end else begin
			present_ff <= !sense_a && !sense_b; // [R14] [R15]
			misseat_ff <= sense_a ^ sense_b; // [R15]
			wp_ff <= wp_s;
		end
	end

	// read word assembly: odd byte arrives on the low lane in byte mode
	always_comb begin
		rd_word = data_sync;
		if (cur_ff.width != width_word) begin
			rd_word = {{byte_w{1'b0}}, data_sync[byte_w-1:0]}; // [R11] [R12]
		end
	end

	// access sequencer; one cycle of the card per accepted request, none for a refused one
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= st_idle;
			cnt_ff <= '0;
			cur_ff <= '0;
			ready_ff <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			refused_ff <= 1'b0;
			case (state_ff)
				st_idle: begin
					ready_ff <= 1'b1;
					if (req_valid && ready_ff) begin
						ready_ff <= 1'b0;
						cur_ff <= req;
						cnt_ff <= '0;
						// no point cycling a write the switch will swallow
						if (!present_ff || (req.write && wp_ff)) begin // [R16]
							refused_ff <= 1'b1;
							state_ff <= st_recover;
						end else if (req.write) begin
							state_ff <= st_vpp; // [R1] [R17]
						end else begin
							state_ff <= st_setup;
						end
					end
				end
				st_vpp: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff >= vpp_len - 1'b1) begin
						cnt_ff <= '0;
						state_ff <= st_setup;
					end
				end
				st_setup: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff >= setup_len - 1'b1) begin
						cnt_ff <= '0;
						state_ff <= st_strobe;
					end
				end
				st_strobe: begin
					cnt_ff <= cnt_ff + 1'b1;
					// reads hold for full access time; writes for the strobe width
					if (cnt_ff >= (cur_ff.write ? strobe_len : access_len) - 1'b1) begin
						cnt_ff <= '0;
						state_ff <= st_recover;
					end
				end
				st_recover: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (cnt_ff >= recover_len - 1'b1) begin
						cnt_ff <= '0;
						state_ff <= st_idle;
					end
				end
				default: begin
					state_ff <= st_idle;
				end
			endcase
		end
	end

	// read response sampled at the end of the access window
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rsp_data_ff <= '0;
			rsp_valid_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= 1'b0;
			if (state_ff == st_strobe && !cur_ff.write && cnt_ff >= access_len - 1'b1) begin
				rsp_data_ff <= rd_word; // [R5] [R9]
				rsp_valid_ff <= 1'b1;
			end
		end
	end

	// socket control pins; selects and supplies per lane
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctl_ff <= '{sel_low_n: 1'b1, sel_high_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				program_low: 1'b0, program_high: 1'b0};
			addr_ff <= '0;
		end else begin
			ctl_ff.oe_n <= !(state_ff == st_strobe && !cur_ff.write);
			// write strobe falls with address settled, rises with data settled
			ctl_ff.we_n <= !(state_ff == st_strobe && cur_ff.write); // [R19] [R21] [R4]
			// selects only around the strobe; held one cycle past a write strobe
			// so the card still sees itself selected when it latches on the rise
			if (state_ff == st_setup || state_ff == st_strobe) begin
				ctl_ff.sel_low_n <= 1'b0; // [R8] [R11]
				ctl_ff.sel_high_n <= (cur_ff.width != width_word); // [R11]
			end else if (ctl_ff.we_n) begin
				ctl_ff.sel_low_n <= 1'b1;
				ctl_ff.sel_high_n <= 1'b1;
			end
			// supply raised from the settle phase on, so it leads the selects
			if (cur_ff.write && cur_ff.program_enable &&
				(state_ff == st_vpp || state_ff == st_setup || state_ff == st_strobe)) begin
				ctl_ff.program_low <= 1'b1; // [R2] [R8]
				ctl_ff.program_high <= (cur_ff.width == width_word) ||
					(cur_ff.width == width_byte_odd);
			end else if (ctl_ff.we_n) begin
				// supply dropped between writes returns zones to read command
				ctl_ff.program_low <= 1'b0; // [R20] [R17]
				ctl_ff.program_high <= 1'b0;
			end
			// lane bit forced low in word mode, parity bit in byte mode
			addr_ff <= {cur_ff.addr[addr_w-1:1], (cur_ff.width == width_byte_odd)}; // [R12] [R13] [R10]
		end
	end

	// data lane drive; released whenever the card may talk
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lo_out_ff <= '0;
			hi_out_ff <= '0;
			lo_oe_ff <= 1'b0;
			hi_oe_ff <= 1'b0;
		end else begin
			// data kept on the lanes until the strobe has risen, the card latches there
			lo_oe_ff <= cur_ff.write && (state_ff == st_setup || state_ff == st_strobe || !ctl_ff.we_n); // [R22]
			hi_oe_ff <= cur_ff.write && (cur_ff.width == width_word) &&
				(state_ff == st_setup || state_ff == st_strobe || !ctl_ff.we_n); // [R11]
			lo_out_ff <= cur_ff.wdata[byte_w-1:0];
			hi_out_ff <= cur_ff.wdata[data_w-1:byte_w];
		end
	end

	assign req_ready = ready_ff;
	assign rsp_data = rsp_data_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_refused = refused_ff;
	assign card_present = present_ff;
	assign card_misseated = misseat_ff;
	assign write_protected = wp_ff;
	assign card_ctl = ctl_ff;
	assign card_addr = addr_ff;
	assign data_low_lane_out = lo_out_ff;
	assign data_high_lane_out = hi_out_ff;
	assign data_low_lane_oe = lo_oe_ff;
	assign data_high_lane_oe = hi_oe_ff;
endmodule : flash_card_host

// >>> verif/flash_card_host_properties.sv
// pin-level assertion checker for the flash card host controller
module flash_card_host_properties
	import card_host_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire card_host_pkg::host_req_t req,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic rsp_refused,
	input wire logic card_present,
	input wire logic card_misseated,
	input wire card_host_pkg::card_ctl_t card_ctl,
	input wire logic [card_host_pkg::addr_w-1:0] card_addr,
	input wire logic data_low_lane_oe,
	input wire logic insert_sense_first_n,
	input wire logic insert_sense_second_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// lane and select pairing; odd-byte and bus-fight checks every cycle, write checks as the strobe falls when all pins have settled
	odd_low_only_a: assert property (!card_ctl.sel_low_n && card_addr[0] |-> card_ctl.sel_high_n)
		else $error("odd byte used high select");
	word_pair_sel_a: assert property ($fell(card_ctl.we_n) && !card_ctl.sel_high_n |->
		!card_ctl.sel_low_n && !card_addr[0])
		else $error("word write select mismatch");
	write_data_held_a: assert property ($fell(card_ctl.we_n) |-> data_low_lane_oe && !card_ctl.sel_low_n)
		else $error("write strobe without data");
	no_bus_fight_a: assert property (data_low_lane_oe |-> card_ctl.oe_n)
		else $error("host drove lane during read");
	// sense bits pass a two-flop sync, so five steady cycles is ample
	misseat_flag_a: assert property ((insert_sense_first_n != insert_sense_second_n) [*5] |-> card_misseated)
		else $error("half-seated card not flagged");
	present_flag_a: assert property ((!insert_sense_first_n && !insert_sense_second_n) [*5] |-> card_present)
		else $error("seated card not reported");
	refuse_quiet_a: assert property (rsp_refused |-> card_ctl.sel_low_n && card_ctl.sel_high_n && card_ctl.we_n)
		else $error("refused request touched pins");
	read_answer_a: assert property (req_valid && req_ready && !req.write && card_present |-> ##69 rsp_valid)
		else $error("read answer late or missing");
	// main traffic kinds
	cover property (rsp_valid);
	cover property (rsp_refused);
	cover property ($fell(card_ctl.we_n) && card_ctl.program_high);
endmodule : flash_card_host_properties

bind flash_card_host flash_card_host_properties u_props (.ref_clk, .resetn, .req, .req_valid, .req_ready,
	.rsp_valid, .rsp_refused, .card_present, .card_misseated, .card_ctl, .card_addr, .data_low_lane_oe,
	.insert_sense_first_n, .insert_sense_second_n);

// >>> verif/card_model.sv
// behavioural flash card answering the host controller pins
module card_model
	import card_host_pkg::*;
(
	input wire card_host_pkg::card_ctl_t card_ctl,
	input wire logic [card_host_pkg::addr_w-1:0] card_addr,
	input wire logic [card_host_pkg::byte_w-1:0] host_low,
	input wire logic [card_host_pkg::byte_w-1:0] host_high,
	input wire logic host_low_oe,
	input wire logic host_high_oe,
	input wire logic [1:0] seated,
	input wire logic write_protect_pin,
	output logic [card_host_pkg::byte_w-1:0] data_low_lane,
	output logic [card_host_pkg::byte_w-1:0] data_high_lane,
	output logic insert_sense_first_n,
	output logic insert_sense_second_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	logic [21:0] lat_addr;
	logic we_int_n;
	logic [7:0] rd_low;
	logic [7:0] rd_high;
	logic supply_ok;
	// never-written cells read as erased zone contents
	function automatic logic [7:0] peek(input int idx);
		return mem.exists(idx) ? mem[idx] : 8'hff;
	endfunction : peek
	// grounded contacts at each end; protect switch pins the strobe high
	assign insert_sense_first_n = !seated[0];
	assign insert_sense_second_n = !seated[1];
	assign we_int_n = card_ctl.we_n | write_protect_pin;
	// a card touching no contact has no main supply and locks its command path
	assign supply_ok = |seated;
	// address taken on strobe fall, data on rise; no supply means no change
	always @(negedge we_int_n) lat_addr = card_addr;
	always @(posedge we_int_n) begin
		if (supply_ok && !card_ctl.sel_low_n &&
			(lat_addr[0] ? card_ctl.program_high : card_ctl.program_low))
			mem[int'(card_ctl.sel_high_n ? lat_addr : lat_addr & ~22'h1)] = data_low_lane;
		if (supply_ok && !card_ctl.sel_high_n && card_ctl.program_high)
			mem[int'(lat_addr | 22'h1)] = data_high_lane;
	end
	// odd byte steered to the low lane; unselected lanes show junk, not stale data
	always @(card_ctl or card_addr) begin
		rd_low = peek(int'(card_ctl.sel_high_n ? card_addr : card_addr & ~22'h1));
		rd_high = peek(int'(card_addr | 22'h1));
	end
	assign data_low_lane = host_low_oe ? host_low : (!card_ctl.sel_low_n && !card_ctl.oe_n) ? rd_low : ~rd_low;
	assign data_high_lane = host_high_oe ? host_high :
		(!card_ctl.sel_high_n && !card_ctl.oe_n) ? rd_high : ~rd_high;
endmodule : card_model

// >>> verif/flash_card_host_tb.sv
// self-checking bench for the flash card host controller
module flash_card_host_tb;
	import card_host_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, resetn = 0, req_valid = 0, wp = 0;
	logic [1:0] seated = 2'b11;
	host_req_t req = '0;
	card_ctl_t ctl;
	logic [21:0] ca;
	logic [7:0] lo_o, hi_o, lo_w, hi_w;
	logic lo_oe, hi_oe, s1_n, s2_n, rdy, rv, rf, pres, mis, wpd;
	logic [15:0] rd;
	int n_errors = 0, checks_done = 0;
	logic [7:0] ref_mem [int];
	always #2 ref_clk = ~ref_clk;
	flash_card_host u_dut (.ref_clk, .resetn, .req, .req_valid, .req_ready(rdy), .rsp_data(rd), .rsp_valid(rv),
		.rsp_refused(rf), .card_present(pres), .card_misseated(mis), .write_protected(wpd), .card_ctl(ctl),
		.card_addr(ca), .data_low_lane_out(lo_o), .data_high_lane_out(hi_o), .data_low_lane_oe(lo_oe),
		.data_high_lane_oe(hi_oe), .data_low_lane_in(lo_w), .data_high_lane_in(hi_w),
		.insert_sense_first_n(s1_n), .insert_sense_second_n(s2_n), .write_protect_pin(wp));
	card_model u_card (.card_ctl(ctl), .card_addr(ca), .host_low(lo_o), .host_high(hi_o), .host_low_oe(lo_oe),
		.host_high_oe(hi_oe), .seated, .write_protect_pin(wp), .data_low_lane(lo_w), .data_high_lane(hi_w),
		.insert_sense_first_n(s1_n), .insert_sense_second_n(s2_n));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", nm, want, seen);
		end
	endtask : chk
	function automatic logic [7:0] rm(input int i);
		return ref_mem.exists(i) ? ref_mem[i] : 8'hff;
	endfunction : rm
	// one request; reference memory only changes when supply is asked for
	task automatic xfer(input logic w, input width_mode_t m, input logic [21:0] a, input logic [15:0] d,
		input logic pe);
		int n;
		int k;
		logic bad;
		n = 0;
		k = (m == width_byte_odd) ? int'(a | 22'h1) : int'(a);
		bad = !pres || (w && wp);
		while (rdy !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("ready wait", n < 400, 1'b1);
		req = '{w, m, a, d, pe};
		req_valid = 1;
		@(posedge ref_clk);
		#1 req_valid = 0;
		n = 0;
		// a write has no answer pulse; it is done once ready returns
		while (rv !== 1'b1 && rf !== 1'b1 && !(w && rdy === 1'b1) && n < 400) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("answer wait", n < 400, 1'b1);
		chk("refused", rf, bad);
		if (!bad && w && pe) begin
			ref_mem[k] = d[7:0];
			if (m == width_word) ref_mem[k + 1] = d[15:8];
		end
		if (!bad && !w) chk("rdata", rd, m == width_word ? {rm(k + 1), rm(k)} : {8'h00, rm(k)});
	endtask : xfer
	task automatic give_verdict();
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// seating, random traffic, protect switch, half-seated card
	initial begin
		width_mode_t m;
		logic [21:0] a;
		logic [15:0] d;
		void'($urandom(6767));
		repeat (10) @(posedge ref_clk);
		#1 resetn = 1;
		repeat (6) @(posedge ref_clk);
		#1 chk("present", pres, 1'b1);
		for (int i = 0; i < 14; i++) begin
			m = width_mode_t'($urandom % 3);
			a = 22'($urandom) & ~22'h1;
			d = 16'($urandom);
			xfer(1, m, a, d, 1'($urandom));
			xfer(0, m, a, 0, 0);
		end
		wp = 1;
		repeat (5) @(posedge ref_clk);
		#1 chk("protected", wpd, 1'b1);
		xfer(1, width_word, a, ~d, 1);
		xfer(0, width_word, a, 0, 0);
		wp = 0;
		seated = 2'b01;
		repeat (5) @(posedge ref_clk);
		#1 chk("misseated", mis, 1'b1);
		xfer(0, width_byte_even, a, 0, 0);
		give_verdict();
	end
	// watchdog, several times the expected run
	initial begin
		#40000;
		n_errors++;
		give_verdict();
	end
endmodule : flash_card_host_tb
